// file: pkg/mwp_pkg.sv
// Functional notes
// RL1 - Page-mode write to read-only page dropped, flag set.
// RL2 - Page register read returns error flag bit 7.
// RL3 - Page register write: bit 7 sets read-only.
// RL4 - Absolute-mode writes skip read-only page check.
// RL5 - Read-only check follows page register used.
// RL6 - DMA writes ignore read-only page marks.
// RL7 - Remote processor writes ignore read-only marks.
// RL8 - Protect checks only while function bit 8 set.
// RL9 - Local violation sets fault flag, raises interrupt.
// RL10 - Unprotected write to protected word blocked.
// RL11 - DMA write from unprotected origin blocked.
// RL12 - Protected fetch after unprotected becomes stop.
// RL13 - Unprotected privileged instructions become selective stop.
// RL14 - Only set/clear instructions change protect bits.
// RL15 - Strictly inside bounds window means unprotected.
// RL16 - Page-mode bounds use logical sixteen-bit address.
// RL17 - Absolute-mode bounds use absolute address.
// RL18 - Bounds always active; upper zero empties window.
// RL19 - Bounds ignored for DMA and remote references.
// RL20 - Faults reported on interrupt line 00.
// RL21 - Fault and page error flags stay until cleared.
package mwp_pkg;
  localparam int MWP_PAGE_W = 8;
  localparam int MWP_WORD_W = 11;
  localparam int MWP_PAGES = 32;
  localparam int MWP_PHYS_W = MWP_PAGE_W + MWP_WORD_W;
  localparam logic [7:0] MWP_OFS_FUNC = 8'h00;
  localparam logic [7:0] MWP_OFS_LOWER = 8'h04;
  localparam logic [7:0] MWP_OFS_UPPER = 8'h08;
  localparam logic [7:0] MWP_OFS_PAGE = 8'h0C;
  localparam logic [7:0] MWP_OFS_CLEAR = 8'h10;
  localparam int MWP_BIT_PROT_EN = 8;
  localparam int MWP_BIT_RO = 7;
  localparam int MWP_BIT_FAULT = 8;
  localparam int MWP_PIDX_LSB = 8;
  localparam int MWP_PPAGE_LSB = 16;
  localparam logic MWP_PROT_EN_RST = 1'b0;
  localparam logic [15:0] MWP_BOUND_RST = 16'h0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic absolute;
    logic dma;
    logic remote;
    logic instr_prot;
    logic src_unprot;
    logic intr_entry;
    logic priv;
    logic set_pb;
    logic clr_pb;
    logic [MWP_PHYS_W-1:0] addr;
  } mwp_req_t;

  typedef struct packed {
    logic valid;
    logic mem_we;
    logic sel_stop;
    logic [MWP_PHYS_W-1:0] addr;
  } mwp_resp_t;
endpackage

// file: rtl/mwp_pb_mem.sv
`timescale 1ns/1ps
module mwp_pb_mem #(
  parameter int AW = 19,
  parameter int DW = 1
)
(
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] wa,
  input wire logic [DW-1:0] wd,
  input wire logic [AW-1:0] ra,
  output logic [DW-1:0] rd
);
  logic [DW-1:0] mem [2**AW];

  if (AW < 1 || DW < 1)
  begin : g_chk
    $error("Memory width and depth must be positive.");
  end

  // Read data come out of a register one cycle after the address.
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[wa] <= wd;
    end
    rd <= mem[ra];
  end
endmodule

// file: rtl/mwp_top.sv
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module mwp_top
  import mwp_pkg::*;
#(
  parameter int PB_AW = MWP_PHYS_W
)
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire mwp_req_t REQ,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output mwp_resp_t RESP,
  output logic RO_ERR,
  output logic INT00
);
  typedef struct packed {
    logic prot_en;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [MWP_PAGES-1:0] ro;
    logic [MWP_PAGES-1:0][MWP_PAGE_W-1:0] ppage;
    logic ro_err;
    logic fault;
    logic last_unprot;
    mwp_req_t s1;
    logic s1_ro;
    logic s1_win;
    mwp_resp_t resp;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mwp_state_t;

  localparam mwp_state_t ST_RST = '{
    prot_en: MWP_PROT_EN_RST,
    lo: MWP_BOUND_RST,
    hi: MWP_BOUND_RST,
    default: '0
  };

  mwp_state_t st_reg;
  mwp_state_t st_next;
  logic v_cpu0;
  logic v_ro_hit;
  logic v_in_win;
  logic [MWP_PHYS_W-1:0] v_phys;
  logic pb_rd;
  logic s1_cpu;
  logic eff_pb;
  logic wr_viol;
  logic fetch_viol;
  logic pbop_viol;
  logic cpu_fault;
  logic pb_we;
  logic apb_wr;
  logic [31:0] clr_bits;

  if (PB_AW != MWP_PHYS_W)
  begin : g_chk
    $error("Protect bit memory must cover the whole physical space.");
  end

  assign v_cpu0 = REQ.valid && !REQ.dma && !REQ.remote;
  // RL5 per page register.
  assign v_phys = (v_cpu0 && !REQ.absolute) ?
    {st_reg.ppage[REQ.addr[15:11]], REQ.addr[MWP_WORD_W-1:0]} :
    (v_cpu0 ? {{(MWP_PHYS_W-16){1'b0}}, REQ.addr[15:0]} : REQ.addr);
  // RL4 absolute bypass, RL6 and RL7 by the CPU-only term.
  assign v_ro_hit = v_cpu0 && REQ.write && !REQ.absolute && st_reg.ro[REQ.addr[15:11]];
  // RL16 logical compare, RL17 absolute compare, RL19 local references only.
  assign v_in_win = v_cpu0 && (REQ.addr[15:0] > st_reg.lo) && (REQ.addr[15:0] < st_reg.hi);

  mwp_pb_mem #(.AW(PB_AW), .DW(1)) u_pb_mem (
    .clk(MCLK),
    .we(pb_we),
    .wa(st_reg.s1.addr),
    .wd(st_reg.s1.set_pb),
    .ra(v_phys),
    .rd(pb_rd)
  );

  assign s1_cpu = st_reg.s1.valid && !st_reg.s1.dma && !st_reg.s1.remote;
  // RL15 window overrides the stored bit.
  assign eff_pb = pb_rd && !st_reg.s1_win;
  // RL10 and RL11 blocked writes.
  assign wr_viol = st_reg.prot_en && st_reg.s1.valid && st_reg.s1.write && eff_pb &&
    (s1_cpu ? !st_reg.s1.instr_prot : st_reg.s1.src_unprot);
  // RL12 and RL13 selective stop.
  assign fetch_viol = st_reg.prot_en && s1_cpu && st_reg.s1.fetch &&
    ((eff_pb && st_reg.last_unprot && !st_reg.s1.intr_entry) || (!eff_pb && st_reg.s1.priv));
  // RL8 gating of set and clear instructions.
  assign pbop_viol = st_reg.prot_en && s1_cpu && (st_reg.s1.set_pb || st_reg.s1.clr_pb) &&
    !st_reg.s1.instr_prot;
  assign cpu_fault = (wr_viol && s1_cpu) || fetch_viol || pbop_viol;
  // RL14 protect bit written only here.
  assign pb_we = s1_cpu && (st_reg.s1.set_pb || st_reg.s1.clr_pb) && !pbop_viol;
  assign apb_wr = PSEL && PENABLE && PWRITE && st_reg.pready;
  assign clr_bits = (apb_wr && PADDR == MWP_OFS_CLEAR) ? PWDATA : 32'h0000_0000;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = REQ;
    st_next.s1.addr = v_phys;
    st_next.s1_ro = v_ro_hit;
    st_next.s1_win = v_in_win;
    st_next.resp.valid = st_reg.s1.valid;
    st_next.resp.addr = st_reg.s1.addr;
    // RL1 drop write.
    st_next.resp.mem_we = st_reg.s1.valid && st_reg.s1.write && !st_reg.s1_ro && !wr_viol;
    st_next.resp.sel_stop = fetch_viol || pbop_viol;
    if (s1_cpu && st_reg.s1.fetch)
    begin
      st_next.last_unprot = !eff_pb;
    end
    // RL1 flag, RL21 set wins over clear.
    st_next.ro_err = (st_reg.ro_err && !clr_bits[MWP_BIT_RO]) || st_reg.s1_ro;
    // RL9 fault flag, RL21 held until cleared.
    st_next.fault = (st_reg.fault && !clr_bits[MWP_BIT_FAULT]) || cpu_fault;
    st_next.pready = 1'b0;
    if (PSEL && PENABLE && !st_reg.pready)
    begin
      st_next.pready = 1'b1;
      st_next.pslverr = 1'b0;
      st_next.prdata = 32'h0000_0000;
      if (PADDR == MWP_OFS_FUNC)
      begin
        st_next.prdata[MWP_BIT_PROT_EN] = st_reg.prot_en;
      end
      else if (PADDR == MWP_OFS_LOWER)
      begin
        st_next.prdata[15:0] = st_reg.lo;
      end
      else if (PADDR == MWP_OFS_UPPER)
      begin
        st_next.prdata[15:0] = st_reg.hi;
      end
      else if (PADDR == MWP_OFS_PAGE)
      begin
        // RL2 error flag in bit 7.
        st_next.prdata[MWP_BIT_RO] = st_reg.ro_err;
        st_next.prdata[MWP_BIT_FAULT] = st_reg.fault;
      end
      else if (PADDR != MWP_OFS_CLEAR)
      begin
        st_next.pslverr = 1'b1;
      end
    end
    if (apb_wr)
    begin
      if (PADDR == MWP_OFS_FUNC)
      begin
        st_next.prot_en = PWDATA[MWP_BIT_PROT_EN];
      end
      // RL18 bounds loads.
      else if (PADDR == MWP_OFS_LOWER)
      begin
        st_next.lo = PWDATA[15:0];
      end
      else if (PADDR == MWP_OFS_UPPER)
      begin
        st_next.hi = PWDATA[15:0];
      end
      // RL3 page register write.
      else if (PADDR == MWP_OFS_PAGE)
      begin
        st_next.ro[PWDATA[MWP_PIDX_LSB+:5]] = PWDATA[MWP_BIT_RO];
        st_next.ppage[PWDATA[MWP_PIDX_LSB+:5]] = PWDATA[MWP_PPAGE_LSB+:MWP_PAGE_W];
      end
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      st_reg <= ST_RST;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign RESP = st_reg.resp;
  assign RO_ERR = st_reg.ro_err;
  // RL20 interrupt line 00.
  assign INT00 = st_reg.fault;

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (SRST);

  a_ro_flag_set: assert property (st_reg.s1_ro |=> RO_ERR) // RL1
    else $error("Read-only hit did not set the page error flag.");
  a_ro_no_write: assert property (st_reg.s1_ro |=> !RESP.mem_we) // RL1
    else $error("Write to a read-only page reached memory.");
  a_abs_bypass: assert property (s1_cpu && st_reg.s1.write && st_reg.s1.absolute &&
    !st_reg.prot_en |=> RESP.mem_we) // RL4
    else $error("Absolute write was blocked.");
  a_dma_no_ro: assert property (st_reg.s1.valid && st_reg.s1.dma && st_reg.s1.write &&
    !st_reg.prot_en |=> RESP.mem_we && !$rose(RO_ERR)) // RL6
    else $error("DMA write was checked against read-only pages.");
  a_gate_off: assert property (!st_reg.prot_en |=> !$rose(INT00) || $past(INT00)) // RL8
    else $error("Fault raised while checking was disabled.");
  a_fault_int: assert property (cpu_fault |=> INT00 ##1 (INT00 || $past(apb_wr))) // RL9
    else $error("Violation did not raise interrupt line 00.");
  a_win_open: assert property (s1_cpu && st_reg.s1.write && st_reg.s1_win && !st_reg.s1_ro
    |=> RESP.mem_we) // RL15
    else $error("Write inside the bounds window was blocked.");
  a_empty_win: assert property (st_reg.hi == 16'h0000 |=> !st_reg.s1_win) // RL18
    else $error("Upper bound zero left a window open.");
  a_flag_hold: assert property (INT00 && !clr_bits[MWP_BIT_FAULT] |=> INT00) // RL21
    else $error("Fault flag dropped without a clear.");
  a_pb_only: assert property (pb_we |-> st_reg.s1.set_pb || st_reg.s1.clr_pb) // RL14
    else $error("Protect bit written by an ordinary access.");
  a_stop_priv: assert property (st_reg.prot_en && s1_cpu && st_reg.s1.fetch && st_reg.s1.priv
    && !pb_rd |=> RESP.sel_stop) // RL13
    else $error("Unprotected privileged fetch did not stop.");

  a_page_ro_hit: assert property (v_cpu0 && REQ.write && !REQ.absolute && // RL1
    st_reg.ro[REQ.addr[15:11]] |=> st_reg.s1_ro)
    else $error("Page-mode write to a read-only page was not caught.");

  a_rd_ro_bit: assert property (PSEL && PENABLE && !PWRITE && !PREADY && // RL2
    PADDR == MWP_OFS_PAGE |=> PRDATA[MWP_BIT_RO] == $past(RO_ERR))
    else $error("Page register read did not return the error flag.");

  a_page_ro_set: assert property (apb_wr && PADDR == MWP_OFS_PAGE |=> // RL3
    st_reg.ro[$past(PWDATA[MWP_PIDX_LSB+:5])] == $past(PWDATA[MWP_BIT_RO]))
    else $error("Page register write did not load the read-only mark.");

  a_abs_no_ro: assert property (v_cpu0 && REQ.absolute |=> !st_reg.s1_ro) // RL4
    else $error("Absolute access was checked against read-only pages.");

  a_page_map: assert property (apb_wr && PADDR == MWP_OFS_PAGE |=> // RL5
    st_reg.ppage[$past(PWDATA[MWP_PIDX_LSB+:5])] ==
    $past(PWDATA[MWP_PPAGE_LSB+:MWP_PAGE_W]))
    else $error("Page register write did not load the physical page.");

  a_ro_per_reg: assert property (v_cpu0 && !REQ.absolute && // RL5
    !st_reg.ro[REQ.addr[15:11]] |=> !st_reg.s1_ro)
    else $error("Read-only hit through an unmarked page register.");

  a_ro_cpu_only: assert property (REQ.valid && (REQ.dma || REQ.remote) |=> // RL6
    !st_reg.s1_ro)
    else $error("Outside access was checked against read-only pages.");

  a_remote_no_ro: assert property (st_reg.s1.valid && st_reg.s1.remote && // RL7
    st_reg.s1.write && !st_reg.prot_en |=> RESP.mem_we && !$rose(RO_ERR))
    else $error("Remote write was checked against read-only pages.");

  a_off_no_stop: assert property (!st_reg.prot_en |=> !RESP.sel_stop) // RL8
    else $error("Stop raised while checking was disabled.");

  a_off_write: assert property (!st_reg.prot_en && st_reg.s1.valid && // RL8
    st_reg.s1.write && !st_reg.s1_ro |=> RESP.mem_we)
    else $error("Write blocked while checking was disabled.");

  a_rd_fault_bit: assert property (PSEL && PENABLE && !PWRITE && !PREADY && // RL9
    PADDR == MWP_OFS_PAGE |=> PRDATA[MWP_BIT_FAULT] == $past(INT00))
    else $error("Page register read did not return the fault flag.");

  a_ext_no_fault: assert property (st_reg.s1.valid && !s1_cpu && !INT00 |=> // RL9
    !INT00)
    else $error("Outside access raised the fault flag.");

  a_unprot_block: assert property (st_reg.prot_en && s1_cpu && st_reg.s1.write && // RL10
    !st_reg.s1.instr_prot && pb_rd && !st_reg.s1_win |=> !RESP.mem_we)
    else $error("Unprotected write reached a protected word.");

  a_unprot_fault: assert property (st_reg.prot_en && s1_cpu && st_reg.s1.write && // RL10
    !st_reg.s1.instr_prot && pb_rd && !st_reg.s1_win |=> INT00)
    else $error("Unprotected write did not set the fault flag.");

  a_dma_block: assert property (st_reg.prot_en && st_reg.s1.valid && st_reg.s1.dma && // RL11
    st_reg.s1.write && st_reg.s1.src_unprot && pb_rd |=> !RESP.mem_we)
    else $error("Transfer from an unprotected origin reached a protected word.");

  a_seq_stop: assert property (st_reg.prot_en && s1_cpu && st_reg.s1.fetch && // RL12
    pb_rd && !st_reg.s1_win && st_reg.last_unprot && !st_reg.s1.intr_entry
    |=> RESP.sel_stop)
    else $error("Protected fetch after an unprotected one did not stop.");

  a_intr_no_stop: assert property (s1_cpu && st_reg.s1.fetch && st_reg.s1.intr_entry && // RL12
    !st_reg.s1.priv && !st_reg.s1.set_pb && !st_reg.s1.clr_pb |=> !RESP.sel_stop)
    else $error("Fetch during an interrupt sequence was stopped.");

  a_pb_write_prot: assert property (pb_we |-> s1_cpu && // RL14
    (!st_reg.prot_en || st_reg.s1.instr_prot))
    else $error("Protect bit changed by an unprotected instruction.");

  a_no_pb_on_write: assert property (st_reg.s1.write && !st_reg.s1.set_pb && // RL14
    !st_reg.s1.clr_pb |-> !pb_we)
    else $error("Ordinary write changed a protect bit.");

  a_win_lower: assert property (v_cpu0 && REQ.addr[15:0] <= st_reg.lo |=> // RL15
    !st_reg.s1_win)
    else $error("Address at or below the lower bound was left open.");

  a_win_upper: assert property (v_cpu0 && REQ.addr[15:0] >= st_reg.hi |=> // RL15
    !st_reg.s1_win)
    else $error("Address at or above the upper bound was left open.");

  a_win_inside: assert property (v_cpu0 && REQ.addr[15:0] > st_reg.lo && // RL16
    REQ.addr[15:0] < st_reg.hi |=> st_reg.s1_win)
    else $error("Logical address inside the bounds was not opened.");

  a_abs_addr: assert property (v_cpu0 && REQ.absolute |=> // RL17
    st_reg.s1.addr[MWP_PHYS_W-1:16] == '0)
    else $error("Absolute access left the first address space.");

  a_upper_zero: assert property (st_reg.hi == 16'h0000 && // RL18
    $past(st_reg.hi) == 16'h0000 && st_reg.prot_en && s1_cpu && st_reg.s1.write &&
    !st_reg.s1.instr_prot && pb_rd |=> !RESP.mem_we)
    else $error("Upper bound zero let an unprotected write through.");

  a_ext_no_win: assert property (st_reg.s1.valid && !s1_cpu |-> !st_reg.s1_win) // RL19
    else $error("Bounds window applied to an outside access.");

  a_int_only_fault: assert property (!INT00 && !cpu_fault |=> !INT00) // RL20
    else $error("Interrupt line 00 rose without a violation.");

  a_int_clear: assert property (apb_wr && PADDR == MWP_OFS_CLEAR && // RL21
    PWDATA[MWP_BIT_FAULT] && !cpu_fault |=> !INT00)
    else $error("Fault flag was not cleared by software.");

  a_ro_clear: assert property (apb_wr && PADDR == MWP_OFS_CLEAR && // RL21
    PWDATA[MWP_BIT_RO] && !st_reg.s1_ro |=> !RO_ERR)
    else $error("Page error flag was not cleared by software.");

  a_ro_hold: assert property (RO_ERR && !clr_bits[MWP_BIT_RO] |=> RO_ERR) // RL21
    else $error("Page error flag dropped without a clear.");
endmodule

// file: testbench/mwp_core_model.sv
`timescale 1ns/1ps
module mwp_core_model
  import mwp_pkg::*;
(
  input wire logic mclk,
  input wire logic go,
  input wire mwp_req_t cmd,
  output mwp_req_t req
);
  mwp_req_t nxt;
  initial req = '0;
  // Between requests the fields toggle so stale values are never reused.
  always @(posedge mclk)
  begin
    nxt = go ? cmd : ~req;
    nxt.valid = go;
    req <= nxt;
  end
endmodule

// file: testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import mwp_pkg::*;
;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, ro_err, int00, go, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  mwp_req_t cmd, req;
  mwp_resp_t resp;
  int mismatches, n_checks;
  localparam logic [10:0] f_wr = 11'h400, f_fe = 11'h200, f_ab = 11'h100, f_dm = 11'h080,
    f_rm = 11'h040, f_ip = 11'h020, f_su = 11'h010, f_ie = 11'h008, f_pv = 11'h004,
    f_sp = 11'h002, f_cp = 11'h001;

  mwp_core_model core (.mclk(mclk), .go(go), .cmd(cmd), .req(req));
  mwp_top DUT (.MCLK(mclk), .SRST(srst), .REQ(req), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RESP(resp), .RO_ERR(ro_err), .INT00(int00));

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, s, x);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    if (pready !== 1'b1)
    begin
      mismatches++;
      stop_test;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One access from the core; an expectation of x is not compared.
  task acc(input logic [10:0] f, input logic [18:0] a, input logic we, input logic st);
    int n;
    @(posedge mclk);
    cmd <= {1'b0, f, a};
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end while (resp.valid !== 1'b1 && n < 8);
    if (resp.valid !== 1'b1)
    begin
      mismatches++;
      stop_test;
    end
    if (we !== 1'bx)
      chk(resp.mem_we, we);
    if (st !== 1'bx)
      chk(resp.sel_stop, st);
  endtask

  initial
  begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    cmd = '0;
    repeat (16) @(posedge mclk);
    srst <= 1'b0;
    apb(1'b0, MWP_OFS_FUNC, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(e, 1'b1);
    acc(f_cp | f_ab | f_ip, 19'h01805, 1'bx, 1'bx);
    acc(f_sp | f_ab | f_ip, 19'h00020, 1'bx, 1'bx);
    acc(f_sp | f_ab | f_ip, 19'h01806, 1'bx, 1'bx);
    $display("test setup done");
    apb(1'b1, MWP_OFS_PAGE, 32'h00030180);
    apb(1'b1, MWP_OFS_PAGE, 32'h00030200);
    acc(f_wr | f_ip, 19'h00805, 1'b0, 1'b0);
    chk(ro_err, 1'b1);
    apb(1'b0, MWP_OFS_PAGE, 32'h0);
    chk(r[7], 1'b1);
    acc(f_wr, 19'h01005, 1'b1, 1'b0);
    chk(resp.addr, 19'h01805);
    acc(f_wr | f_ab, 19'h01805, 1'b1, 1'b0);
    acc(f_wr | f_dm, 19'h01805, 1'b1, 1'b0);
    acc(f_wr | f_rm, 19'h01805, 1'b1, 1'b0);
    chk(ro_err, 1'b1);
    apb(1'b1, MWP_OFS_CLEAR, 32'h00000080);
    #1;
    chk(ro_err, 1'b0);
    apb(1'b1, MWP_OFS_PAGE, 32'h00030100);
    acc(f_wr, 19'h00805, 1'b1, 1'b0);
    chk(ro_err, 1'b0);
    $display("test read_only done");
    acc(f_wr, 19'h00020, 1'b1, 1'b0);
    apb(1'b1, MWP_OFS_FUNC, 32'h00000100);
    acc(f_wr, 19'h00020, 1'b0, 1'b0);
    chk(int00, 1'b1);
    acc(f_wr | f_ip, 19'h00020, 1'b1, 1'b0);
    acc(f_wr, 19'h00020, 1'b0, 1'b0);
    apb(1'b0, MWP_OFS_PAGE, 32'h0);
    chk(r[8], 1'b1);
    apb(1'b1, MWP_OFS_CLEAR, 32'h00000100);
    acc(f_wr | f_dm | f_su, 19'h00020, 1'b0, 1'b0);
    chk(int00, 1'b0);
    $display("test protect_bit done");
    apb(1'b1, MWP_OFS_LOWER, 32'h0000001F);
    apb(1'b1, MWP_OFS_UPPER, 32'h00000021);
    acc(f_wr, 19'h00020, 1'b1, 1'b0);
    acc(f_wr | f_dm | f_su, 19'h00020, 1'b0, 1'b0);
    apb(1'b1, MWP_OFS_LOWER, 32'h00000020);
    acc(f_wr, 19'h00020, 1'b0, 1'b0);
    apb(1'b1, MWP_OFS_LOWER, 32'h00000805);
    apb(1'b1, MWP_OFS_UPPER, 32'h00000807);
    acc(f_wr, 19'h00806, 1'b1, 1'b0);
    acc(f_wr | f_ab, 19'h01806, 1'b0, 1'b0);
    apb(1'b1, MWP_OFS_LOWER, 32'h0);
    apb(1'b1, MWP_OFS_UPPER, 32'h0);
    acc(f_wr, 19'h00020, 1'b0, 1'b0);
    apb(1'b1, MWP_OFS_CLEAR, 32'h00000100);
    $display("test bounds done");
    acc(f_fe | f_ab, 19'h01805, 1'bx, 1'b0);
    acc(f_fe | f_ab | f_ie, 19'h00020, 1'bx, 1'b0);
    acc(f_fe | f_ab, 19'h01805, 1'bx, 1'b0);
    acc(f_fe | f_ab, 19'h00020, 1'bx, 1'b1);
    acc(f_fe | f_ab | f_pv, 19'h01805, 1'bx, 1'b1);
    chk(int00, 1'b1);
    $display("test fetch done");
    stop_test;
  end
endmodule
